// File: shared/lock_monitor_defines.svh
// Constants for the input lock and clock identity monitor
`ifndef LOCK_MONITOR_DEFINES_SVH
`define LOCK_MONITOR_DEFINES_SVH

`define LM_N_SRC 10
`define LM_N_EXT 9
`define LM_N_PIN_TICK 8
`define LM_AUDIO_W 24
`define LM_CNT_W 8

`define LM_REF_CLK_PERIOD_NS 5
`define LM_INT_SAMPLE_PERIOD_NS 20833

`define LM_WINDOW_LEN 8'h40
`define LM_LOCK_TOL 8'h01
`define LM_DRIFT_TOL 8'h04
`define LM_PASS_DELAY 3

`define LM_CS_PRO_BIT 0
`define LM_CS_AUDIO_BIT 1
`define LM_CS_PRO_EMPH_LSB 2
`define LM_CS_PRO_LOCK_BIT 5
`define LM_CS_PRO_FS_LSB 6
`define LM_CS_CON_COPY_BIT 2
`define LM_CS_CON_EMPH_LSB 3
`define LM_CS_CON_MODE_LSB 6

`endif

// File: shared/lock_monitor_pkg.sv
// Types shared by the input lock and clock identity monitor
package lock_monitor_pkg;

    typedef enum logic [3:0] {
        src_internal,
        src_aes,
        src_consumer,
        src_opt0,
        src_opt1,
        src_opt2,
        src_opt3,
        src_video,
        src_timecode,
        src_word
    } clk_src_t;

    typedef enum logic [1:0] {
        state_no_lock,
        state_lock,
        state_sync
    } lock_state_t;

    typedef enum logic {
        mode_master,
        external_clock_follow_mode
    } clock_mode_t;

    typedef struct packed {
        logic pro_format;
        logic non_audio;
        logic [2:0] emphasis;
        logic pro_lock_flag;
        logic [1:0] pro_sample_freq;
        logic copy_permit;
        logic [1:0] con_mode;
    } cs_fields_t;

endpackage

// File: rtl/cs_byte0_collector.sv
// Gathers channel-status byte 0 from the per-frame status bit stream
`timescale 1ns/10ps
`default_nettype none
module cs_byte0_collector (
    input wire logic link_clk,
    input wire logic link_rst,
    input wire logic cs_bit,
    input wire logic cs_bit_valid,
    input wire logic cs_block_start,
    output logic [7:0] cs_byte,
    output logic byte_done
);
    logic [7:0] shift;
    logic [7:0] next_shift;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic active;
    logic next_active;
    logic [7:0] next_cs_byte;
    logic next_byte_done;

    // Bit 0 arrives first with the block start, so it settles in the lsb
    always_comb begin
        next_shift = shift;
        next_bit_cnt = bit_cnt;
        next_active = active;
        next_cs_byte = cs_byte;
        next_byte_done = 1'b0;
        if (cs_bit_valid) begin
            if (cs_block_start) begin
                next_shift = {cs_bit, 7'h00};
                next_bit_cnt = 4'h1;
                next_active = 1'b1;
            end else if (active) begin
                next_shift = {cs_bit, shift[7:1]};
                next_bit_cnt = bit_cnt + 4'h1;
                if (bit_cnt == 4'h7) begin
                    next_active = 1'b0;
                    next_cs_byte = {cs_bit, shift[7:1]};
                    next_byte_done = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            shift <= 8'h00;
            bit_cnt <= 4'h0;
            active <= 1'b0;
            cs_byte <= 8'h00;
            byte_done <= 1'b0;
        end else begin
            shift <= next_shift;
            bit_cnt <= next_bit_cnt;
            active <= next_active;
            cs_byte <= next_cs_byte;
            byte_done <= next_byte_done;
        end
    end
endmodule
`default_nettype wire

// File: rtl/tick_window_counter.sv
// Per-input tick counter with lock tracking and identity compare
`timescale 1ns/10ps
`default_nettype none
`include "lock_monitor_defines.svh"
module tick_window_counter #(
    parameter bit ANY_EDGE = 1'b0
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic tick_pin,
    input wire logic lock_pin,
    input wire logic window_end,
    output logic tick,
    output logic locked,
    output logic in_sync
);
    logic [2:0] tick_pipe;
    logic [1:0] lock_pipe;
    logic [`LM_CNT_W-1:0] count;
    logic [`LM_CNT_W-1:0] last;
    logic [`LM_CNT_W-1:0] total;
    logic [`LM_CNT_W-1:0] diff;
    logic [`LM_CNT_W-1:0] next_count;
    logic [`LM_CNT_W-1:0] next_last;
    logic next_locked;
    logic next_in_sync;

    function automatic logic [`LM_CNT_W-1:0] abs_diff(input logic [`LM_CNT_W-1:0] a,
                                                     input logic [`LM_CNT_W-1:0] b);
        abs_diff = (a > b) ? a - b : b - a;
    endfunction

    // Only the second synchroniser stage and its delayed copy feed the edge test
    assign tick = ANY_EDGE ? (tick_pipe[1] ^ tick_pipe[2]) : (tick_pipe[1] & ~tick_pipe[2]);
    assign total = (tick && count != 8'hff) ? count + 8'h01 : count;
    assign diff = abs_diff(total, last);

    always_comb begin
        next_count = total;
        next_last = last;
        next_locked = locked;
        next_in_sync = in_sync;
        if (window_end) begin
            next_count = 8'h00;
            next_last = total;
            if (total == 8'h00) begin
                next_locked = 1'b0;
            end else if (!locked) begin
                next_locked = (last != 8'h00) && (diff <= `LM_LOCK_TOL);
            end else begin
                next_locked = diff <= `LM_DRIFT_TOL;
            end
            next_in_sync = next_locked && (total == `LM_WINDOW_LEN);
        end
        if (!lock_pipe[1]) begin
            next_locked = 1'b0;
            next_in_sync = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tick_pipe <= 3'h0;
            lock_pipe <= 2'h0;
            count <= 8'h00;
            last <= 8'h00;
            locked <= 1'b0;
            in_sync <= 1'b0;
        end else begin
            tick_pipe <= {tick_pipe[1:0], tick_pin};
            lock_pipe <= {lock_pipe[0], lock_pin};
            count <= next_count;
            last <= next_last;
            locked <= next_locked;
            in_sync <= next_in_sync;
        end
    end
endmodule
`default_nettype wire

// File: rtl/input_lock_sync_monitor.sv
// Lock and clock identity monitor for the digital audio inputs
// What this block does
// - Byte 0 bit 0 picks professional or consumer
// - Professional: audio flag, emphasis, locked, frequency
// - Consumer: audio flag, copy, emphasis, mode
// - Lock when frequency matches; hold through drift
// - Report each source as no lock, lock, sync
// - Sync only when clock identical to clock used
// - Master internal clock; follow mode uses input while it is locked
// - Receiver to transmitter path delays three samples
// - Sources: internal, AES, consumer, optical, video, timecode, word
`timescale 1ns/10ps
`default_nettype none
`include "lock_monitor_defines.svh"
module input_lock_sync_monitor #(
    parameter int unsigned INT_SAMPLE_DIV = `LM_INT_SAMPLE_PERIOD_NS / `LM_REF_CLK_PERIOD_NS
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire lock_monitor_pkg::clock_mode_t clock_mode,
    input wire lock_monitor_pkg::clk_src_t ref_select,
    input wire logic [`LM_N_EXT-1:0] ext_pll_locked,
    input wire logic [`LM_N_PIN_TICK-1:0] ext_tick,
    input wire logic cs_bit,
    input wire logic cs_bit_valid,
    input wire logic cs_block_start,
    input wire logic rx_sample_valid,
    input wire logic [`LM_AUDIO_W-1:0] rx_sample,
    output logic [`LM_AUDIO_W-1:0] tx_sample,
    output logic tx_sample_valid,
    output var lock_monitor_pkg::lock_state_t source_state [`LM_N_SRC],
    output var lock_monitor_pkg::clk_src_t clock_in_use,
    output logic sample_tick,
    output logic cs_valid,
    output logic pro_format,
    output logic non_audio,
    output logic [2:0] emphasis,
    output logic pro_lock_flag,
    output logic [1:0] pro_sample_freq,
    output logic copy_permit,
    output logic [1:0] con_mode
);
    import lock_monitor_pkg::*;

    function automatic cs_fields_t decode_cs(input logic [7:0] b);
        decode_cs = '0;
        decode_cs.pro_format = b[`LM_CS_PRO_BIT];
        decode_cs.non_audio = b[`LM_CS_AUDIO_BIT];
        if (b[`LM_CS_PRO_BIT]) begin
            decode_cs.emphasis = b[`LM_CS_PRO_EMPH_LSB +: 3];
            decode_cs.pro_lock_flag = b[`LM_CS_PRO_LOCK_BIT];
            decode_cs.pro_sample_freq = b[`LM_CS_PRO_FS_LSB +: 2];
        end else begin
            decode_cs.copy_permit = b[`LM_CS_CON_COPY_BIT];
            decode_cs.emphasis = b[`LM_CS_CON_EMPH_LSB +: 3];
            decode_cs.con_mode = b[`LM_CS_CON_MODE_LSB +: 2];
        end
    endfunction

    // ---------------- Link clock domain ----------------
    logic [1:0] link_rst_pipe;
    logic link_rst;
    logic aes_toggle;
    logic next_aes_toggle;
    logic [`LM_AUDIO_W-1:0] pass_pipe [`LM_PASS_DELAY];
    logic [`LM_AUDIO_W-1:0] next_pass_pipe [`LM_PASS_DELAY];
    logic [`LM_AUDIO_W-1:0] next_tx_sample;
    logic [7:0] coll_byte;
    logic coll_done;
    logic [7:0] hold_byte;
    logic [7:0] next_hold_byte;
    logic cs_req;
    logic next_cs_req;
    logic [1:0] ack_pipe;
    logic cs_ack;

    // Reset asserts at once but releases on a link edge; the link may stop between frames
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            link_rst_pipe <= 2'h3;
        end else begin
            link_rst_pipe <= {link_rst_pipe[0], 1'b0};
        end
    end
    assign link_rst = link_rst_pipe[1];

    cs_byte0_collector u_collector (
        .link_clk(link_clk),
        .link_rst(link_rst),
        .cs_bit(cs_bit),
        .cs_bit_valid(cs_bit_valid),
        .cs_block_start(cs_block_start),
        .cs_byte(coll_byte),
        .byte_done(coll_done)
    );

    always_comb begin
        next_aes_toggle = aes_toggle ^ rx_sample_valid;
        next_pass_pipe = pass_pipe;
        next_tx_sample = tx_sample;
        if (rx_sample_valid) begin
            next_tx_sample = pass_pipe[`LM_PASS_DELAY-1];
            next_pass_pipe[0] = rx_sample;
            for (int i = 1; i < `LM_PASS_DELAY; i++) begin
                next_pass_pipe[i] = pass_pipe[i-1];
            end
        end
        // A byte finished while the previous one is still crossing is dropped;
        // the next block repeats it a few milliseconds later
        next_hold_byte = hold_byte;
        next_cs_req = cs_req;
        if (coll_done && (cs_req == ack_pipe[1])) begin
            next_hold_byte = coll_byte;
            next_cs_req = ~cs_req;
        end
    end

    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            aes_toggle <= 1'b0;
            pass_pipe <= '{default: '0};
            tx_sample <= '0;
            tx_sample_valid <= 1'b0;
            hold_byte <= 8'h00;
            cs_req <= 1'b0;
            ack_pipe <= 2'h0;
        end else begin
            aes_toggle <= next_aes_toggle;
            pass_pipe <= next_pass_pipe;
            tx_sample <= next_tx_sample;
            tx_sample_valid <= rx_sample_valid;
            hold_byte <= next_hold_byte;
            cs_req <= next_cs_req;
            ack_pipe <= {ack_pipe[0], cs_ack};
        end
    end

    // ---------------- Reference clock domain ----------------
    logic [12:0] div_cnt;
    logic [12:0] next_div_cnt;
    logic int_tick;
    logic [`LM_N_EXT-1:0] ext_tick_level;
    logic [`LM_N_EXT-1:0] ext_edge;
    logic [`LM_N_EXT-1:0] ext_locked;
    logic [`LM_N_EXT-1:0] ext_in_sync;
    logic active_tick;
    logic [7:0] win_cnt;
    logic [7:0] next_win_cnt;
    logic window_end;
    clk_src_t next_clock_in_use;
    lock_state_t next_source_state [`LM_N_SRC];
    logic [1:0] req_pipe;
    logic next_cs_ack;
    cs_fields_t cs_fields;
    cs_fields_t next_cs_fields;
    logic next_cs_valid;
    logic [3:0] sel_idx;

    // Internal sample clock for master mode
    assign int_tick = (div_cnt == 13'(INT_SAMPLE_DIV - 1));
    assign next_div_cnt = int_tick ? 13'h0000 : div_cnt + 13'h0001;

    // AES ticks cross as a toggle; other sources arrive as sample-rate pins
    assign ext_tick_level = {ext_tick, aes_toggle};

    for (genvar g = 0; g < `LM_N_EXT; g++) begin : g_src
        tick_window_counter #(
            .ANY_EDGE(g == 0)
        ) u_counter (
            .ref_clk(ref_clk),
            .rst(rst),
            .tick_pin(ext_tick_level[g]),
            .lock_pin(ext_pll_locked[g]),
            .window_end(window_end),
            .tick(ext_edge[g]),
            .locked(ext_locked[g]),
            .in_sync(ext_in_sync[g])
        );
    end

    assign sel_idx = 4'(ref_select) - 4'h1;
    assign active_tick = (clock_in_use == src_internal) ? int_tick : ext_edge[4'(clock_in_use) - 4'h1];
    // Window is a fixed number of ticks of the clock in use
    assign window_end = active_tick && (win_cnt == `LM_WINDOW_LEN - 8'h01);
    assign next_win_cnt = window_end ? 8'h00 : (active_tick ? win_cnt + 8'h01 : win_cnt);

    always_comb begin
        // Falls back to the internal clock while the chosen input is not locked
        next_clock_in_use = src_internal;
        if (clock_mode == external_clock_follow_mode && ref_select != src_internal
            && ext_locked[sel_idx]) begin
            next_clock_in_use = ref_select;
        end
        next_source_state[0] = (clock_in_use == src_internal) ? state_sync : state_lock;
        for (int i = 0; i < `LM_N_EXT; i++) begin
            if (!ext_locked[i]) begin
                next_source_state[i+1] = state_no_lock;
            end else if (ext_in_sync[i]) begin
                next_source_state[i+1] = state_sync;
            end else begin
                next_source_state[i+1] = state_lock;
            end
        end
        next_cs_ack = cs_ack;
        next_cs_fields = cs_fields;
        next_cs_valid = cs_valid;
        if (req_pipe[1] != cs_ack) begin
            next_cs_ack = req_pipe[1];
            next_cs_fields = decode_cs(hold_byte);
            next_cs_valid = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            div_cnt <= 13'h0000;
            win_cnt <= 8'h00;
            clock_in_use <= src_internal;
            source_state <= '{default: state_no_lock};
            sample_tick <= 1'b0;
            req_pipe <= 2'h0;
            cs_ack <= 1'b0;
            cs_fields <= '0;
            cs_valid <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            win_cnt <= next_win_cnt;
            clock_in_use <= next_clock_in_use;
            source_state <= next_source_state;
            sample_tick <= active_tick;
            req_pipe <= {req_pipe[0], cs_req};
            cs_ack <= next_cs_ack;
            cs_fields <= next_cs_fields;
            cs_valid <= next_cs_valid;
        end
    end

    assign pro_format = cs_fields.pro_format;
    assign non_audio = cs_fields.non_audio;
    assign emphasis = cs_fields.emphasis;
    assign pro_lock_flag = cs_fields.pro_lock_flag;
    assign pro_sample_freq = cs_fields.pro_sample_freq;
    assign copy_permit = cs_fields.copy_permit;
    assign con_mode = cs_fields.con_mode;
endmodule
`default_nettype wire

// File: verification/lock_monitor_properties.sv
// Port-level assertions for the lock and clock identity monitor
`timescale 1ns/10ps
`default_nettype none
`include "lock_monitor_defines.svh"
module lock_monitor_properties (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire lock_monitor_pkg::clock_mode_t clock_mode,
    input wire lock_monitor_pkg::clk_src_t ref_select,
    input wire logic [`LM_N_EXT-1:0] ext_pll_locked,
    input wire logic rx_sample_valid,
    input wire logic tx_sample_valid,
    input wire lock_monitor_pkg::lock_state_t source_state [`LM_N_SRC],
    input wire lock_monitor_pkg::clk_src_t clock_in_use,
    input wire logic sample_tick,
    input wire logic pro_format,
    input wire logic pro_lock_flag,
    input wire logic [1:0] pro_sample_freq,
    input wire logic copy_permit,
    input wire logic [1:0] con_mode
);
    import lock_monitor_pkg::*;
    // Pin low through both sync stages and the state update
    for (genvar k = 1; k < `LM_N_SRC; k++) begin : g_pin
        a_pin_drop: assert property (@(posedge ref_clk) disable iff (rst)
            !ext_pll_locked[k-1] [*5] |-> source_state[k] == state_no_lock)
            else $error("locked state kept after pin low");
    end
    a_master_internal: assert property (@(posedge ref_clk) disable iff (rst)
        clock_mode == mode_master [*3] |-> clock_in_use == src_internal)
        else $error("master mode not on internal clock");
    a_use_needs_follow: assert property (@(posedge ref_clk) disable iff (rst)
        clock_in_use != src_internal |-> $past(clock_mode) == external_clock_follow_mode)
        else $error("external clock used outside follow mode");
    a_follow_fallback: assert property (@(posedge ref_clk) disable iff (rst)
        (clock_mode == external_clock_follow_mode
         && source_state[ref_select] == state_no_lock) [*3]
        |-> clock_in_use == src_internal)
        else $error("unlocked source kept in use");
    a_tick_pulse: assert property (@(posedge ref_clk) disable iff (rst)
        sample_tick |=> !sample_tick)
        else $error("sample tick wider than one cycle");
    a_tx_answer: assert property (@(posedge link_clk) disable iff (rst)
        rx_sample_valid |=> tx_sample_valid)
        else $error("received sample not passed on");
    a_tx_cause: assert property (@(posedge link_clk) disable iff (rst)
        tx_sample_valid |-> $past(rx_sample_valid))
        else $error("output strobe without input strobe");
    a_pro_clears_con: assert property (@(posedge ref_clk) disable iff (rst)
        pro_format |-> !copy_permit && con_mode == 2'h0)
        else $error("consumer fields set in professional layout");
    a_con_clears_pro: assert property (@(posedge ref_clk) disable iff (rst)
        !pro_format |-> !pro_lock_flag && pro_sample_freq == 2'h0)
        else $error("professional fields set in consumer layout");
endmodule
bind input_lock_sync_monitor lock_monitor_properties props (.ref_clk, .rst, .link_clk,
    .clock_mode, .ref_select, .ext_pll_locked, .rx_sample_valid, .tx_sample_valid,
    .source_state, .clock_in_use, .sample_tick, .pro_format, .pro_lock_flag,
    .pro_sample_freq, .copy_permit, .con_mode);
`default_nettype wire

// File: verification/audio_source_model.sv
// Model of the external digital audio equipment feeding the inputs
`timescale 1ns/10ps
`default_nettype none
`include "lock_monitor_defines.svh"
module audio_source_model #(
    parameter int FAST = 16,
    parameter int SLOW = 17
) (
    input wire logic ref_clk,
    input wire logic link_clk,
    input wire logic [`LM_N_EXT-1:0] lock_en,
    output logic [`LM_N_EXT-1:0] ext_pll_locked,
    output logic [`LM_N_PIN_TICK-1:0] ext_tick,
    output logic cs_bit,
    output logic cs_bit_valid,
    output logic cs_block_start,
    output logic rx_sample_valid,
    output logic [`LM_AUDIO_W-1:0] rx_sample
);
    assign ext_pll_locked = lock_en;
    // Pin 1 runs slightly slow so it locks but never matches the card
    for (genvar i = 0; i < `LM_N_PIN_TICK; i++) begin : g_tick
        localparam int PER = (i == 1) ? SLOW : FAST;
        int cnt = 0;
        logic t = 1'b0;
        assign ext_tick[i] = t;
        always @(posedge ref_clk) begin
            cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
            t <= #1 (cnt < PER / 2);
        end
    end
    initial begin
        cs_bit = 1'b0;
        cs_bit_valid = 1'b0;
        cs_block_start = 1'b0;
        rx_sample_valid = 1'b0;
        rx_sample = 24'h000000;
    end
    task automatic send_cs(input logic [7:0] b);
        for (int n = 0; n < 8; n++) begin
            @(posedge link_clk);
            #1;
            cs_bit_valid = 1'b1;
            cs_bit = b[n];
            cs_block_start = (n == 0);
        end
        @(posedge link_clk);
        #1;
        cs_bit_valid = 1'b0;
        cs_block_start = 1'b0;
        cs_bit = ~cs_bit;
    endtask
    task automatic put_sample(input logic [23:0] d);
        @(posedge link_clk);
        #1;
        rx_sample_valid = 1'b1;
        rx_sample = d;
    endtask
    // Idle data is scrambled so a stale sample cannot pass by luck
    task automatic idle_sample();
        @(posedge link_clk);
        #1;
        rx_sample_valid = 1'b0;
        rx_sample = ~rx_sample;
    endtask
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking testbench for the lock and clock identity monitor
`timescale 1ns/10ps
`default_nettype none
`include "lock_monitor_defines.svh"
module tb_top;
    import lock_monitor_pkg::*;
    logic ref_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst = 1'b1;
    clock_mode_t clock_mode = mode_master;
    clk_src_t ref_select = src_internal;
    logic [8:0] lock_en = 9'h000;
    logic [8:0] pll;
    logic [7:0] tick;
    logic cs_bit, cs_bit_valid, cs_block_start, rx_sample_valid, tx_sample_valid;
    logic [23:0] rx_sample, tx_sample;
    logic sample_tick, cs_valid, pro_format, non_audio, pro_lock_flag, copy_permit;
    logic [2:0] emphasis;
    logic [1:0] pro_sample_freq, con_mode;
    lock_state_t source_state [`LM_N_SRC];
    clk_src_t clock_in_use;
    int fails = 0;
    int checked = 0;
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        #7;
        forever #15 link_clk = ~link_clk;
    end
    input_lock_sync_monitor #(.INT_SAMPLE_DIV(16)) dut (.ref_clk, .rst, .link_clk,
        .clock_mode, .ref_select, .ext_pll_locked(pll), .ext_tick(tick), .cs_bit,
        .cs_bit_valid, .cs_block_start, .rx_sample_valid, .rx_sample, .tx_sample,
        .tx_sample_valid, .source_state, .clock_in_use, .sample_tick, .cs_valid,
        .pro_format, .non_audio, .emphasis, .pro_lock_flag, .pro_sample_freq,
        .copy_permit, .con_mode);
    audio_source_model far_end (.ref_clk, .link_clk, .lock_en, .ext_pll_locked(pll),
        .ext_tick(tick), .cs_bit, .cs_bit_valid, .cs_block_start, .rx_sample_valid,
        .rx_sample);
    task automatic test_done();
        if (fails == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic t_reset();
        step(3);
        chk(32'(source_state[src_internal]), 32'(state_sync));
        chk(32'(source_state[src_aes]), 32'(state_no_lock));
        chk(32'(clock_in_use), 32'(src_internal));
        chk(32'(cs_valid), 32'h0);
        repeat (3) @(posedge link_clk);
    endtask
    // Back-to-back strobes; output of each strobe is read the edge after
    task automatic t_pass();
        logic [23:0] exp;
        for (int j = 0; j < 8; j++) begin
            if (j < 6)
                far_end.put_sample(24'h100000 + 24'(j) * 24'h010101);
            else
                far_end.idle_sample();
            if (j > 0) begin
                exp = (j < 4) ? 24'h000000 : 24'h100000 + 24'(j - 4) * 24'h010101;
                chk(32'(tx_sample_valid), (j < 7) ? 32'h1 : 32'h0);
                if (j < 7) chk(32'(tx_sample), 32'(exp));
            end
        end
    endtask
    task automatic t_status();
        logic [7:0] b [2] = '{8'hb5, 8'h6e};
        logic [10:0] exp;
        for (int i = 0; i < 2; i++) begin
            far_end.send_cs(b[i]);
            step(30);
            if (b[i][0])
                exp = {1'b1, b[i][1], b[i][4:2], b[i][5], b[i][7:6], 3'h0};
            else
                exp = {1'b0, b[i][1], b[i][5:3], 3'h0, b[i][2], b[i][7:6]};
            chk(32'({pro_format, non_audio, emphasis, pro_lock_flag, pro_sample_freq,
                copy_permit, con_mode}), 32'(exp));
            chk(32'(cs_valid), 32'h1);
        end
    endtask
    // Master mode with a divide of 16: any 128 straight cycles hold exactly 8 pulses
    task automatic t_tick();
        int n;
        n = 0;
        for (int c = 0; c < 128; c++) begin
            step(1);
            if (sample_tick === 1'b1) n++;
        end
        chk(32'(n), 32'h8);
    endtask
    // Consumer pin matches the card exactly, first optical pin runs slow
    task automatic t_lock();
        lock_en = 9'h006;
        step(6000);
        chk(32'(source_state[src_consumer]), 32'(state_sync));
        chk(32'(source_state[src_opt0]), 32'(state_lock));
        chk(32'(source_state[src_aes]), 32'(state_no_lock));
        chk(32'(source_state[src_internal]), 32'(state_sync));
        lock_en[2] = 1'b0;
        step(8);
        chk(32'(source_state[src_opt0]), 32'(state_no_lock));
    endtask
    task automatic t_follow();
        clock_mode = external_clock_follow_mode;
        for (int k = 1; k < 10; k++) begin
            if (k == 2) continue;
            ref_select = clk_src_t'(k);
            step(6);
            chk(32'(clock_in_use), 32'(src_internal));
        end
        ref_select = src_consumer;
        step(6);
        chk(32'(clock_in_use), 32'(src_consumer));
        step(4000);
        chk(32'(source_state[src_internal]), 32'(state_lock));
        chk(32'(source_state[src_consumer]), 32'(state_sync));
        clock_mode = mode_master;
        step(6);
        chk(32'(clock_in_use), 32'(src_internal));
    endtask
    // Reset is held five link cycles; t_reset then waits out the two link edges the slow domain needs after release
    initial begin
        repeat (5) @(posedge link_clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_pass();
        t_status();
        t_tick();
        t_lock();
        t_follow();
        test_done();
    end
    initial begin
        #300000;
        fails++;
        test_done();
    end
endmodule
`default_nettype wire
